// [dmsd_params.svh]
`ifndef DMSD_PARAMS_SVH
`define DMSD_PARAMS_SVH
// ==========================================
// Address space sizes
`define DMSD_CODE_SPACE_BYTES 65536
`define DMSD_CODE_ONCHIP_BYTES 4096
`define DMSD_VECTOR_LIMIT 16'h003B
`define DMSD_LOWER_RAM_TOP 8'h7F
`define DMSD_UPPER_RAM_BASE 8'h80
`define DMSD_BANK_AREA_TOP 8'h1F
// ==========================================
// Status register field positions
`define DMSD_BANK_SEL_LOW_POS 3
`define DMSD_BANK_SEL_HIGH_POS 4
// ==========================================
// Reset values
`define DMSD_RAM_RESET 8'h00
`endif

// [dmsd_pkg.sv]
package dmsd_pkg;
	typedef enum logic [2:0] {
		DMSD_MODE_DIRECT = 3'h1,
		DMSD_MODE_INDIRECT = 3'h2,
		DMSD_MODE_REGISTER = 3'h4
	} dmsd_mode_e;
	typedef enum logic [2:0] {
		DMSD_TGT_NONE = 3'h1,
		DMSD_TGT_RAM = 3'h2,
		DMSD_TGT_SPECIAL = 3'h4
	} dmsd_tgt_e;
	typedef struct packed {
		logic valid;
		logic write;
		dmsd_mode_e mode;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dmsd_data_req_s;
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dmsd_special_req_s;
endpackage

// [dmsd_ram.sv]
`timescale 1ns/1ps
module dmsd_ram #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic clock,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];
	// ==========================================
	// Synchronous array with registered read
	always_ff @(posedge clock) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

// [dmsd_decoder.sv]
// Behaviour
// - Code and data are separate spaces
// - Linear 64K code address range
// - Vectors sit in lowest 60 code bytes
// - Table loads reach whole on-chip code
// - Low 128 bytes: direct and indirect
// - Upper 128 RAM only by indirect
// - Direct upper addresses reach function registers
// - Low 32 bytes: four banks of eight
// - Status bits 3 and 4 pick bank
// - Register operand stays in active bank
// - No external data memory path
`timescale 1ns/1ps
`include "dmsd_params.svh"
module dmsd_decoder
	import dmsd_pkg::*;
#(
	parameter int CODE_AW = 16,
	parameter int ONCHIP_BYTES = `DMSD_CODE_ONCHIP_BYTES
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic fetch_valid,
	input wire logic [CODE_AW-1:0] fetch_addr,
	input wire logic code_constant_load,
	input wire logic [7:0] program_status_register,
	input wire dmsd_data_req_s data_req,
	input wire logic [7:0] special_function_register_rdata,
	output dmsd_special_req_s special_function_register_req,
	output logic code_onchip_sel,
	output logic code_vector_area,
	output logic [CODE_AW-1:0] code_mem_addr,
	output logic data_rvalid,
	output logic [7:0] data_rdata,
	output logic [2:0] data_target
);
	// ==========================================
	// Program space decode
	wire logic code_in_range;
	wire logic code_in_vectors;
	assign code_in_range = {16'h0000, fetch_addr} < 32'(ONCHIP_BYTES);
	assign code_in_vectors = fetch_addr <= CODE_AW'(`DMSD_VECTOR_LIMIT);
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			code_onchip_sel <= 1'b0;
			code_vector_area <= 1'b0;
			code_mem_addr <= '0;
		end else begin
			code_onchip_sel <= fetch_valid & code_in_range;
			code_vector_area <= fetch_valid & ~code_constant_load & code_in_vectors;
			code_mem_addr <= fetch_addr;
		end
	end
	// ==========================================
	// Bank select and register address
	wire logic bank_select_low_bit;
	wire logic bank_select_high_bit;
	wire logic [7:0] reg_ram_addr;
	assign bank_select_low_bit = program_status_register[`DMSD_BANK_SEL_LOW_POS];
	assign bank_select_high_bit = program_status_register[`DMSD_BANK_SEL_HIGH_POS];
	assign reg_ram_addr = {3'h0, bank_select_high_bit, bank_select_low_bit,
		data_req.addr[2:0]};
	// ==========================================
	// Data space decode
	wire logic is_direct;
	wire logic is_indirect;
	wire logic is_register;
	wire logic upper_half;
	wire logic hit_special;
	wire logic hit_ram;
	wire logic [7:0] ram_addr;
	assign is_direct = data_req.mode == DMSD_MODE_DIRECT;
	assign is_indirect = data_req.mode == DMSD_MODE_INDIRECT;
	assign is_register = data_req.mode == DMSD_MODE_REGISTER;
	assign upper_half = data_req.addr >= `DMSD_UPPER_RAM_BASE;
	assign hit_special = data_req.valid & is_direct & upper_half;
	assign hit_ram = data_req.valid & (is_indirect | is_register
		| (is_direct & ~upper_half));
	assign ram_addr = is_register ? reg_ram_addr : data_req.addr;
	// ==========================================
	// Internal RAM
	logic [7:0] ram_rdata;
	dmsd_ram #(
		.WIDTH(8),
		.DEPTH(256),
		.AW(8)
	) u_ram (
		.clock(clock),
		.we(hit_ram & data_req.write),
		.addr(ram_addr),
		.wdata(data_req.wdata),
		.rdata(ram_rdata)
	);
	// ==========================================
	// Function register port, forwarded unchanged
	assign special_function_register_req.valid = hit_special;
	assign special_function_register_req.write = hit_special & data_req.write;
	assign special_function_register_req.addr = data_req.addr;
	assign special_function_register_req.wdata = data_req.wdata;
	// ==========================================
	// Read return, one cycle after request
	logic rd_ram_reg;
	logic rd_special_reg;
	logic rd_ram_next;
	logic rd_special_next;
	assign rd_ram_next = hit_ram & ~data_req.write;
	assign rd_special_next = hit_special & ~data_req.write;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rd_ram_reg <= 1'b0;
			rd_special_reg <= 1'b0;
			data_target <= DMSD_TGT_NONE;
		end else begin
			rd_ram_reg <= rd_ram_next;
			rd_special_reg <= rd_special_next;
			data_target <= hit_special ? DMSD_TGT_SPECIAL
				: hit_ram ? DMSD_TGT_RAM : DMSD_TGT_NONE;
		end
	end
	assign data_rvalid = rd_ram_reg | rd_special_reg;
	assign data_rdata = rd_special_reg ? special_function_register_rdata
		: rd_ram_reg ? ram_rdata : `DMSD_RAM_RESET;
endmodule

// [dmsd_sfr_model.sv]
`timescale 1ns/1ps
module dmsd_register_space_model import dmsd_pkg::*; (
	input wire logic clock,
	input wire dmsd_special_req_s special_function_register_req,
	output logic [7:0] special_function_register_rdata
);
	// ==========================================
	// Answer next cycle, scramble when idle
	initial special_function_register_rdata = 8'hC3;
	always @(posedge clock) begin
		if (special_function_register_req.valid) begin
			special_function_register_rdata <= special_function_register_req.addr ^ 8'h5A;
		end else begin
			special_function_register_rdata <= ~special_function_register_rdata;
		end
	end
endmodule

// [dmsd_asserts.sv]
`timescale 1ns/1ps
module dmsd_asserts import dmsd_pkg::*; #(
	parameter int CODE_AW = 16,
	parameter int ONCHIP_BYTES = 4096
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic fetch_valid,
	input wire logic [CODE_AW-1:0] fetch_addr,
	input wire logic code_constant_load,
	input wire dmsd_data_req_s data_req,
	input wire dmsd_special_req_s special_function_register_req,
	input wire logic code_onchip_sel,
	input wire logic code_vector_area,
	input wire logic [CODE_AW-1:0] code_mem_addr,
	input wire logic data_rvalid,
	input wire logic [2:0] data_target
);
// ====
// Access checks
default clocking @(posedge clock); endclocking
default disable iff (sys_rst);
wire hi = data_req.valid && data_req.mode == DMSD_MODE_DIRECT && data_req.addr[7];
wire ram = data_req.valid && !hi && data_req.mode inside {3'h1, 3'h2, 3'h4};
sequence s_rd;
	(hi || ram) && !data_req.write;
endsequence
AST_SPECIAL_SEL: assert property (hi |-> special_function_register_req.valid
	&& special_function_register_req.addr == data_req.addr) else $error("special sel");
AST_SPECIAL_ONLY: assert property (special_function_register_req.valid |-> hi)
	else $error("special only");
AST_RD_ANS: assert property (s_rd |=> data_rvalid) else $error("no answer");
AST_RV_ONLY: assert property (data_rvalid |-> $past((hi || ram) && !data_req.write))
	else $error("stray answer");
AST_TGT_NONE: assert property (data_req.valid && !hi && !ram |=> data_target == 3'h1)
	else $error("none tgt");
AST_TGT_SPECIAL: assert property (hi |=> data_target == 3'h4) else $error("special tgt");
AST_TGT_RAM: assert property (ram |=> data_target == 3'h2) else $error("ram tgt");
AST_CADDR: assert property (fetch_valid |=> code_mem_addr == $past(fetch_addr))
	else $error("code addr");
AST_ONCHIP: assert property (fetch_valid |=> code_onchip_sel == $past(fetch_addr) < ONCHIP_BYTES)
	else $error("onchip");
AST_VEC: assert property (fetch_valid |=> code_vector_area ==
	(!$past(code_constant_load) && $past(fetch_addr) <= 16'h003B)) else $error("vector");
endmodule
bind dmsd_decoder dmsd_asserts #(.CODE_AW(CODE_AW), .ONCHIP_BYTES(ONCHIP_BYTES)) dmsd_asserts_inst (
	.clock(clock), .sys_rst(sys_rst), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
	.code_constant_load(code_constant_load), .data_req(data_req),
	.special_function_register_req(special_function_register_req),
	.code_onchip_sel(code_onchip_sel), .code_vector_area(code_vector_area),
	.code_mem_addr(code_mem_addr), .data_rvalid(data_rvalid), .data_target(data_target));

// [data_memory_space_decoder_bench.sv]
`timescale 1ns/1ps
module data_memory_space_decoder_bench import dmsd_pkg::*; ;
logic clock = 0, rst = 1, fv = 0, ld = 0, rv, os, va, w;
logic [15:0] fa = 0, ca, cor [6] = '{16'h003B, 16'h003A, 16'h003C, 16'h07FF, 16'h0800, 16'hFFFF};
logic [7:0] ps = 0, sd, rd, a, x, j, mem [256];
logic [2:0] tg;
dmsd_data_req_s rq = '0;
dmsd_special_req_s sq;
dmsd_mode_e m;
int failures = 0, comparisons = 0, seed = 92221, i;
always #12.5 clock = ~clock;
dmsd_decoder #(.ONCHIP_BYTES(2048)) dmsd_decoder_inst (.clock(clock), .sys_rst(rst),
	.fetch_valid(fv), .fetch_addr(fa), .code_constant_load(ld), .program_status_register(ps),
	.data_req(rq), .special_function_register_rdata(sd), .special_function_register_req(sq),
	.code_onchip_sel(os), .code_vector_area(va),
	.code_mem_addr(ca), .data_rvalid(rv), .data_rdata(rd), .data_target(tg));
dmsd_register_space_model dmsd_register_space_model_inst (.clock(clock),
	.special_function_register_req(sq), .special_function_register_rdata(sd));
task automatic chk(string n, logic [15:0] s, logic [15:0] e);
	comparisons++;
	if (s !== e) begin
		failures++;
		$display("ERROR %s exp %h seen %h", n, e, s);
	end
endtask
task stop_test;
	$display("comparisons %0d failures %0d", comparisons, failures);
	if (failures == 0 && comparisons > 0) $display("TB: PASS");
	else $display("TB: FAIL");
	$finish;
endtask
initial begin
	#100000 failures++;
	stop_test;
end
initial begin
	repeat (12) @(posedge clock);
	#1 rst = 0;
	chk("tgt", tg, 3'h1);
	for (i = 0; i < 256; i++) begin
		mem[i] = $random(seed);
		rq = '{1'b1, 1'b1, DMSD_MODE_INDIRECT, i[7:0], mem[i]};
		@(posedge clock);
		#1;
	end
	for (i = 0; i < 400; i++) begin
		{a, x, ps} = $random(seed);
		m = dmsd_mode_e'(3'h1 << (i % 3));
		w = i[1] && !(m == DMSD_MODE_DIRECT && a[7]);
		j = m == DMSD_MODE_REGISTER ? {3'h0, ps[4:3], a[2:0]} : a;
		{fv, ld} = {1'b1, i[0]};
		fa = i < 6 ? cor[i] : {i[3] ? 8'h00 : 8'($random(seed)), a};
		rq = '{1'b1, w, m, a, x};
		@(posedge clock);
		#1;
		chk("caddr", ca, fa);
		chk("onchip", os, fa < 2048);
		chk("vector", va, !ld && fa <= 16'h003B);
		chk("rvalid", rv, !w);
		chk("tgt", tg, j[7] && m == DMSD_MODE_DIRECT ? 3'h4 : 3'h2);
		if (w) chk("idle", rd, 8'h00);
		else chk("rdata", rd, j[7] && m == DMSD_MODE_DIRECT ? a ^ 8'h5A : mem[j]);
		if (w) mem[j] = x;
	end
	rq = '{1'b1, 1'b0, dmsd_mode_e'(3'h3), 8'h05, 8'h00};
	@(posedge clock);
	#1;
	chk("bad mode tgt", tg, 3'h1);
	chk("bad mode rvalid", rv, 1'b0);
	chk("bad mode rdata", rd, 8'h00);
	rst = 1;
	repeat (2) @(posedge clock);
	#1 rst = 0;
	chk("rst tgt", tg, 3'h1);
	chk("rst onchip", os, 1'b0);
	chk("rst caddr", ca, 16'h0000);
	{fv, rq.valid} = 2'b00;
	stop_test;
end
endmodule
